// ### rtl/logic_input_pkg.sv
/*
 * Constants for the logic input routing block: register offsets, field
 * widths, reset values and timing.
 * Assumes a 10 MHz APB clock and 32-bit aligned register words.
 */
package logic_input_pkg;
    // -----------------------------------------------------------------
    // Register byte offsets
    // -----------------------------------------------------------------
    localparam logic [11:0] OFF_INPUT_STATUS = 12'h000;
    localparam logic [11:0] OFF_DEST_BASE = 12'h010;
    localparam logic [11:0] OFF_DEST_LAST = 12'h030;
    localparam logic [11:0] OFF_NORMAL_LOGIC = 12'h040;
    localparam logic [11:0] OFF_INVERT = 12'h044;
    localparam logic [11:0] OFF_FUNC_ENABLE = 12'h048;
    localparam logic [11:0] OFF_DRIVE_STATUS = 12'h04C;
    localparam logic [11:0] OFF_LATCHED_BASE = 12'h080;
    localparam logic [11:0] OFF_LATCHED_LAST = 12'h0A0;

    // -----------------------------------------------------------------
    // Fields and reset values
    // -----------------------------------------------------------------
    localparam int NUM_INPUTS = 10;
    localparam int NUM_PROG = 9;
    localparam int DEST_W = 11;
    localparam logic [10:0] DEST_MAX = 11'h7CF;
    localparam logic [10:0] DEST_RESET = 11'h000;
    localparam logic NORMAL_DIS_RESET = 1'b1;
    localparam int BIT_RUN_PERMIT = 0;
    localparam int BIT_IN2 = 1;
    localparam int BIT_IN3 = 2;
    localparam int BIT_IN4 = 3;
    localparam int BIT_IN5 = 4;
    localparam int BIT_ENABLE_STATUS = 10;
    localparam int FE_INCH_REV = 0;
    localparam int FE_INCH_FWD = 1;
    localparam int FE_RUN_REV = 2;
    localparam int FE_RUN_FWD = 3;

    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int FIRING_OFF_DELAY_S = 30;
    localparam longint FIRING_OFF_CYCLES = longint'(FIRING_OFF_DELAY_S) * CLK_HZ;
endpackage

// ### rtl/logic_input_routing.sv
/*
 * Logic input unit: samples eleven terminal inputs, shows their status,
 * routes programmable inputs to destination codes, derives the fixed
 * sequencing commands and holds an APB register slave.
 * Assumes terminal inputs are already synchronous to pclk and that the
 * drive reset arrives as presetn or the drive_reset pulse.
 */
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none

module logic_input_routing #(
    parameter longint FIRING_OFF_CYCLES = logic_input_pkg::FIRING_OFF_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic run_permit_input,
    input wire logic logic_input_two,
    input wire logic logic_input_three,
    input wire logic logic_input_four,
    input wire logic logic_input_five,
    input wire logic external_trip_input,
    input wire logic logic_input_seven,
    input wire logic logic_input_eight,
    input wire logic logic_input_nine,
    input wire logic logic_input_ten,
    input wire logic drive_enable_input,
    input wire logic drive_reset,
    input wire logic drive_running,
    input wire logic ramp_hold,
    output logic ref_zero,
    output logic drive_stop,
    output logic drive_permit,
    output logic firing_off,
    output logic coast_stop,
    output logic ramp_reset,
    output logic inch_reverse,
    output logic inch_forward,
    output logic run_reverse,
    output logic run_forward,
    output logic [logic_input_pkg::NUM_PROG-1:0] route_valid,
    output logic [logic_input_pkg::NUM_PROG*logic_input_pkg::DEST_W-1:0] route_dest,
    output logic [logic_input_pkg::NUM_PROG-1:0] route_level
);
    localparam int NP = logic_input_pkg::NUM_PROG;
    localparam int DW = logic_input_pkg::DEST_W;
    localparam int CW = 40;
    localparam logic [CW-1:0] FIRE_CNT = CW'(FIRING_OFF_CYCLES);

    // -----------------------------------------------------------------
    // Input sampling
    // -----------------------------------------------------------------
    logic [10:0] in_raw;
    logic [10:0] in_q;
    logic [10:0] in_d;

    assign in_raw = {drive_enable_input, logic_input_ten, logic_input_nine,
                     logic_input_eight, logic_input_seven, external_trip_input,
                     logic_input_five, logic_input_four, logic_input_three,
                     logic_input_two, run_permit_input};

    // One stage only: pins arrive already synchronous to pclk
    always_comb begin
        in_d = in_raw;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_q <= 11'h000;
        end else begin
            in_q <= in_d;
        end
    end

    // -----------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------
    logic [DW-1:0] dest_q [NP];
    logic [DW-1:0] dest_d [NP];
    logic [DW-1:0] latch_q [NP];
    logic [DW-1:0] latch_d [NP];
    logic normal_dis_q;
    logic normal_dis_d;
    logic [NP-1:0] invert_q;
    logic [NP-1:0] invert_d;
    logic [3:0] func_en_q;
    logic [3:0] func_en_d;
    logic wr_en;
    logic [11:0] dest_off;
    logic [3:0] dest_idx;
    logic dest_hit;

    assign wr_en = psel && penable && pwrite;
    assign dest_off = paddr - logic_input_pkg::OFF_DEST_BASE;
    assign dest_idx = dest_off[5:2];
    assign dest_hit = (paddr >= logic_input_pkg::OFF_DEST_BASE)
                   && (paddr <= logic_input_pkg::OFF_DEST_LAST) && (paddr[1:0] == 2'b00);

    always_comb begin
        for (int i = 0; i < NP; i++) begin
            dest_d[i] = dest_q[i];
            latch_d[i] = latch_q[i];
            // Out-of-range codes are dropped, not clipped to the limit
            if (wr_en && dest_hit && dest_idx == 4'(i)
                && pwdata <= 32'(logic_input_pkg::DEST_MAX)) begin
                dest_d[i] = pwdata[DW-1:0];
            end
            if (drive_reset) begin
                latch_d[i] = dest_q[i];
            end
        end
        normal_dis_d = normal_dis_q;
        invert_d = invert_q;
        func_en_d = func_en_q;
        if (wr_en && paddr == logic_input_pkg::OFF_NORMAL_LOGIC) begin
            normal_dis_d = pwdata[0];
        end
        if (wr_en && paddr == logic_input_pkg::OFF_INVERT) begin
            invert_d = pwdata[NP-1:0];
        end
        if (wr_en && paddr == logic_input_pkg::OFF_FUNC_ENABLE) begin
            func_en_d = pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NP; i++) begin
                dest_q[i] <= logic_input_pkg::DEST_RESET;
                latch_q[i] <= logic_input_pkg::DEST_RESET;
            end
            normal_dis_q <= logic_input_pkg::NORMAL_DIS_RESET;
            invert_q <= '0;
            func_en_q <= 4'h0;
        end else begin
            dest_q <= dest_d;
            latch_q <= latch_d;
            normal_dis_q <= normal_dis_d;
            invert_q <= invert_d;
            func_en_q <= func_en_d;
        end
    end

    // -----------------------------------------------------------------
    // Routing of programmable inputs two to ten
    // -----------------------------------------------------------------
    logic [NP-1:0] func_lvl;

    // Routing always follows the latched copy, never the live register
    for (genvar g = 0; g < NP; g++) begin : g_route
        assign func_lvl[g] = in_q[g+1] ^ invert_q[g];
        assign route_valid[g] = (latch_q[g] != logic_input_pkg::DEST_RESET);
        assign route_dest[g*DW +: DW] = latch_q[g];
        assign route_level[g] = func_lvl[g];
    end

    // -----------------------------------------------------------------
    // Fixed sequencing functions
    // -----------------------------------------------------------------
    logic [3:0] dir_sel;
    always_comb begin
        // Run permit and enable never pass through the routing table
        dir_sel = normal_dis_q ? func_en_q : 4'hF;
    end
    assign inch_reverse = dir_sel[logic_input_pkg::FE_INCH_REV]
                          && func_lvl[logic_input_pkg::BIT_IN2-1];
    assign inch_forward = dir_sel[logic_input_pkg::FE_INCH_FWD]
                          && func_lvl[logic_input_pkg::BIT_IN3-1];
    assign run_reverse = dir_sel[logic_input_pkg::FE_RUN_REV]
                         && func_lvl[logic_input_pkg::BIT_IN4-1];
    assign run_forward = dir_sel[logic_input_pkg::FE_RUN_FWD]
                         && func_lvl[logic_input_pkg::BIT_IN5-1];

    logic permit;
    logic enabled;
    assign permit = in_q[logic_input_pkg::BIT_RUN_PERMIT];
    assign enabled = in_q[logic_input_pkg::BIT_ENABLE_STATUS];
    assign ref_zero = !permit;
    assign drive_stop = !permit && !ramp_hold;
    assign drive_permit = enabled;

    // -----------------------------------------------------------------
    // Enable loss: delayed firing off, coast stop
    // -----------------------------------------------------------------
    logic [CW-1:0] fire_cnt_q;
    logic [CW-1:0] fire_cnt_d;
    logic firing_off_q;
    logic firing_off_d;
    logic coast_q;
    logic coast_d;
    logic enabled_prev_q;

    always_comb begin
        fire_cnt_d = fire_cnt_q;
        firing_off_d = firing_off_q;
        coast_d = coast_q;
        if (enabled) begin
            fire_cnt_d = '0;
            firing_off_d = 1'b0;
            coast_d = 1'b0;
        end else begin
            if (fire_cnt_q < FIRE_CNT) begin
                fire_cnt_d = fire_cnt_q + CW'(1);
            end
            if (fire_cnt_q + CW'(1) >= FIRE_CNT) begin
                firing_off_d = 1'b1;
            end
            // Latched so the coast persists after the motor spins down
            if (enabled_prev_q && drive_running) begin
                coast_d = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fire_cnt_q <= '0;
            firing_off_q <= 1'b0;
            coast_q <= 1'b0;
            enabled_prev_q <= 1'b0;
        end else begin
            fire_cnt_q <= fire_cnt_d;
            firing_off_q <= firing_off_d;
            coast_q <= coast_d;
            enabled_prev_q <= enabled;
        end
    end

    assign firing_off = firing_off_q;
    assign coast_stop = coast_q;
    assign ramp_reset = coast_q;

    // -----------------------------------------------------------------
    // APB read path, zero wait states
    // -----------------------------------------------------------------
    logic [31:0] rd_d;
    logic [31:0] rd_q;
    logic err_d;
    logic [11:0] lat_off;
    logic [3:0] lat_idx;
    logic lat_hit;

    assign lat_off = paddr - logic_input_pkg::OFF_LATCHED_BASE;
    assign lat_idx = lat_off[5:2];
    assign lat_hit = (paddr >= logic_input_pkg::OFF_LATCHED_BASE)
                  && (paddr <= logic_input_pkg::OFF_LATCHED_LAST) && (paddr[1:0] == 2'b00);

    always_comb begin
        rd_d = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr == logic_input_pkg::OFF_INPUT_STATUS) begin
            rd_d = {21'h000000, in_q};
        end else if (dest_hit) begin
            for (int i = 0; i < NP; i++) begin
                if (dest_idx == 4'(i)) begin
                    rd_d = {21'h000000, dest_q[i]};
                end
            end
        end else if (lat_hit) begin
            for (int i = 0; i < NP; i++) begin
                if (lat_idx == 4'(i)) begin
                    rd_d = {21'h000000, latch_q[i]};
                end
            end
        end else if (paddr == logic_input_pkg::OFF_NORMAL_LOGIC) begin
            rd_d = {31'h00000000, normal_dis_q};
        end else if (paddr == logic_input_pkg::OFF_INVERT) begin
            rd_d = {23'h000000, invert_q};
        end else if (paddr == logic_input_pkg::OFF_FUNC_ENABLE) begin
            rd_d = {28'h0000000, func_en_q};
        end else if (paddr == logic_input_pkg::OFF_DRIVE_STATUS) begin
            rd_d = {28'h0000000, coast_q, firing_off_q, enabled, permit};
        end else begin
            err_d = 1'b1;
        end
        if (pwrite && paddr == logic_input_pkg::OFF_INPUT_STATUS) begin
            err_d = 1'b1;
        end
    end

    // Captured in setup so the word stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            rd_q <= rd_d;
        end
    end

    assign prdata = rd_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && err_d;

    // -----------------------------------------------------------------
    // Checks: sequencing functions
    // -----------------------------------------------------------------
    a_ref_zero_permit: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(run_permit_input) |=> ref_zero)
        else $error("reference not zeroed on permit loss");
    a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!permit && ramp_hold) |-> !drive_stop)
        else $error("stop asserted during ramp hold");
    a_enable_status: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> drive_permit == $past(drive_enable_input))
        else $error("permit does not follow enable");
    a_firing_early: assert property (@(posedge pclk) disable iff (!presetn)
        (enabled && $past(enabled)) |=> !firing_off)
        else $error("firing off while enabled");
    // Holds only while the delay is at least two cycles
    a_firing_after_loss: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(firing_off) |-> !$past(enabled) && !$past(enabled, 2))
        else $error("firing off without a long enable loss");
    a_coast_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (enabled_prev_q && !enabled && drive_running) |=> coast_stop && ramp_reset)
        else $error("no coast stop on enable loss");
    a_coast_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (!coast_stop && !drive_running) |=> !coast_stop)
        else $error("coast stop without a running drive");
    a_permit_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> ref_zero == !$past(run_permit_input))
        else $error("run permit function moved");

    // -----------------------------------------------------------------
    // Checks: status and routing
    // -----------------------------------------------------------------
    a_status_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> in_q == $past(in_raw))
        else $error("status not one cycle after input");
    a_status_write: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == logic_input_pkg::OFF_INPUT_STATUS) |-> pslverr)
        else $error("status write not refused");
    a_dest_range: assert property (@(posedge pclk) disable iff (!presetn)
        route_dest[DW-1:0] <= logic_input_pkg::DEST_MAX)
        else $error("destination beyond range");
    a_unrouted_zero: assert property (@(posedge pclk) disable iff (!presetn)
        route_valid[0] == (route_dest[DW-1:0] != logic_input_pkg::DEST_RESET))
        else $error("valid flag disagrees with destination");
    a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(drive_reset) |-> $stable(latch_q[0]))
        else $error("routing changed without reset");
    a_latch_take: assert property (@(posedge pclk) disable iff (!presetn)
        $past(drive_reset) |-> latch_q[0] == $past(dest_q[0]))
        else $error("routing not taken at reset");
    a_normal_map: assert property (@(posedge pclk) disable iff (!presetn)
        !normal_dis_q |-> run_forward == func_lvl[logic_input_pkg::BIT_IN5-1])
        else $error("run forward not mapped");
    a_shared_level: assert property (@(posedge pclk) disable iff (!presetn)
        !normal_dis_q |-> inch_forward == route_level[logic_input_pkg::BIT_IN3-1])
        else $error("inch forward and routing disagree");
    a_disabled_map: assert property (@(posedge pclk) disable iff (!presetn)
        (normal_dis_q && !func_en_q[logic_input_pkg::FE_INCH_REV]) |-> !inch_reverse)
        else $error("inch reverse active while dropped");
    a_invert_sense: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> route_level[0] == ($past(logic_input_two) ^ invert_q[0]))
        else $error("invert sense wrong");
    a_func_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (normal_dis_q && func_en_q[logic_input_pkg::FE_RUN_REV])
            |-> run_reverse == route_level[logic_input_pkg::BIT_IN4-1])
        else $error("run reverse not enabled");
endmodule // logic_input_routing

`default_nettype wire

// ### testbench/terminal_switches.sv
/*
 * Terminal contact model: external switches and relay contacts that set
 * the eleven logic input levels from a commanded contact pattern.
 * Assumes the bench changes the pattern right after a rising pclk edge.
 */
`timescale 1ns/1ps
`default_nettype none
module terminal_switches (
    input wire logic [10:0] closed,
    output logic run_permit,
    output logic [8:0] prog,
    output logic enable
);
    // Clean levels only: the block expects debounced, synchronous contacts
    assign run_permit = closed[0];
    assign prog = closed[9:1];
    assign enable = closed[10];
endmodule // terminal_switches
`default_nettype wire

// ### testbench/tb_top.sv
/*
 * Self-checking bench for the logic input routing block: APB master,
 * table of terminal patterns, then hand-written routing and timing cases.
 * Assumes pready answers within the bench timeout and a 10 MHz pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin failures++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
    typedef struct packed {logic [10:0] sw; logic hold; logic stop;} row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err, drive_reset, drive_running, ramp_hold, run_permit, enable;
    logic ref_zero, drive_stop, drive_permit, firing_off, coast_stop, ramp_reset;
    logic inch_reverse, inch_forward, run_reverse, run_forward;
    logic [10:0] sw;
    logic [8:0] prog, route_valid, route_level;
    logic [98:0] route_dest;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    row_t rows[7] = '{'{11'h7FF, 0, 0}, '{11'h000, 0, 1}, '{11'h000, 1, 0},
        '{11'h555, 0, 0}, '{11'h2AA, 1, 0}, '{11'h3FE, 0, 1}, '{11'h401, 0, 0}};

    terminal_switches i_sw (.closed(sw), .run_permit(run_permit), .prog(prog), .enable(enable));
    logic_input_routing #(.FIRING_OFF_CYCLES(20)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_permit_input(run_permit),
        .logic_input_two(prog[0]), .logic_input_three(prog[1]), .logic_input_four(prog[2]),
        .logic_input_five(prog[3]), .external_trip_input(prog[4]),
        .logic_input_seven(prog[5]), .logic_input_eight(prog[6]),
        .logic_input_nine(prog[7]), .logic_input_ten(prog[8]),
        .drive_enable_input(enable), .drive_reset(drive_reset),
        .drive_running(drive_running), .ramp_hold(ramp_hold), .ref_zero(ref_zero),
        .drive_stop(drive_stop), .drive_permit(drive_permit), .firing_off(firing_off),
        .coast_stop(coast_stop), .ramp_reset(ramp_reset), .inch_reverse(inch_reverse),
        .inch_forward(inch_forward), .run_reverse(run_reverse), .run_forward(run_forward),
        .route_valid(route_valid), .route_dest(route_dest), .route_level(route_level));

    // ---------------------------------------------------------------
    // Clock, timeout and verdict
    // ---------------------------------------------------------------
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Whole run is well under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            end_sim();
        end
    end

    // ---------------------------------------------------------------
    // APB master tasks, entered just after a rising edge
    // ---------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the bench timeout ends a wait for pready
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        `CHK(nm, ex, rd)
    endtask

    task automatic settle(input logic [10:0] s);
        sw <= s;
        repeat (3) @(posedge pclk);
    endtask

    function automatic logic [3:0] dirs();
        return {run_forward, run_reverse, inch_forward, inch_reverse};
    endfunction

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        presetn <= 1'b0;
        {psel, penable, pwrite, drive_reset, drive_running, ramp_hold} <= 6'h00;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        sw <= 11'h000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("normal_dis", 12'h040, 32'h1);
        rdchk("invert", 12'h044, 32'h0);
        for (int i = 0; i < 9; i++) begin
            rdchk("dest", 12'h010 + 12'(4 * i), 32'h0);
        end
        foreach (rows[i]) begin
            ramp_hold <= rows[i].hold;
            settle(rows[i].sw);
            rdchk("status", 12'h000, {21'h0, rows[i].sw});
            `CHK("ref_zero", ~rows[i].sw[0], ref_zero)
            `CHK("drive_stop", rows[i].stop, drive_stop)
            `CHK("drive_permit", rows[i].sw[10], drive_permit)
            `CHK("route_level", rows[i].sw[9:1], route_level)
            `CHK("dirs_off", 4'h0, dirs())
            `CHK("coast_idle", 1'b0, coast_stop)
        end
        apb(1'b1, 12'h000, 32'h0);
        `CHK("ro_err", 1'b1, err)
        apb(1'b0, 12'hFFC, 32'h0);
        `CHK("unmapped_err", 1'b1, err)
        // Destination writes must not route until a drive reset
        apb(1'b1, 12'h010, 32'h7CF);
        apb(1'b1, 12'h010, 32'h7D0);
        rdchk("dest_max", 12'h010, 32'h7CF);
        apb(1'b1, 12'h030, 32'h5);
        `CHK("valid_before", 9'h000, route_valid)
        rdchk("latched_before", 12'h080, 32'h0);
        drive_reset <= 1'b1;
        @(posedge pclk);
        drive_reset <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK("valid_after", 9'h101, route_valid)
        `CHK("dest_in2", 11'h7CF, route_dest[10:0])
        `CHK("dest_in10", 11'h005, route_dest[98:88])
        rdchk("latched_after", 12'h080, 32'h7CF);
        apb(1'b1, 12'h040, 32'h0);
        for (int k = 0; k < 4; k++) begin
            settle(11'h401 | (11'h2 << k));
            `CHK("dirs_normal", 4'h1 << k, dirs())
            `CHK("level_normal", 9'h1 << k, route_level)
        end
        apb(1'b1, 12'h044, 32'h1);
        settle(11'h401);
        `CHK("level_inv", 9'h001, route_level)
        `CHK("inch_rev_inv", 1'b1, inch_reverse)
        apb(1'b1, 12'h044, 32'h0);
        apb(1'b1, 12'h040, 32'h1);
        settle(11'h41F);
        `CHK("dirs_disabled", 4'h0, dirs())
        apb(1'b1, 12'h048, 32'hF);
        rdchk("func_en", 12'h048, 32'hF);
        `CHK("dirs_func_en", 4'hF, dirs())
        // Enable lost while running: coast now, firing off after delay
        drive_running <= 1'b1;
        settle(11'h401);
        settle(11'h001);
        `CHK("coast", 2'b11, ({coast_stop, ramp_reset}))
        `CHK("permit_off", 1'b0, drive_permit)
        rdchk("drv_status", 12'h04C, 32'h9);
        repeat (8) @(posedge pclk);
        `CHK("firing_early", 1'b0, firing_off)
        repeat (25) @(posedge pclk);
        `CHK("firing_late", 1'b1, firing_off)
        settle(11'h401);
        `CHK("firing_back", 1'b0, firing_off)
        presetn <= 1'b0;
        @(posedge pclk);
        `CHK("rst_ref_zero", 1'b1, ref_zero)
        `CHK("rst_permit", 1'b0, drive_permit)
        `CHK("rst_coast", 1'b0, coast_stop)
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("rst_normal", 12'h040, 32'h1);
        `CHK("rst_valid", 9'h000, route_valid)
        `CHK("rst_dirs", 4'h0, dirs())
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
